// >>> design/cise_pkg.sv
// Shared constants and types of the instruction subset executor.
// Assumes one instruction cycle per rising sys_clk_i edge and an APB slave port.
package cise_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int APB_AW = 8;
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int FADDR_W = 7;

  // ----------------------------------------
  // Register offsets and fields
  // ----------------------------------------
  localparam logic [APB_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [APB_AW-1:0] STAT_OFS = 8'h04;
  localparam logic [APB_AW-1:0] ACC_OFS = 8'h08;
  localparam logic [APB_AW-1:0] PC_OFS = 8'h0c;
  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_C_BIT = 0;
  localparam int STAT_DC_BIT = 1;
  localparam int STAT_Z_BIT = 2;
  localparam int STAT_PD_BIT = 3;
  localparam int STAT_TO_BIT = 4;
  localparam int STAT_GIE_BIT = 5;
  localparam int STAT_SLEEP_BIT = 6;
  localparam int STAT_RUN_BIT = 7;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic TO_RST = 1'b1;
  localparam logic PD_RST = 1'b1;
  localparam logic GIE_RST = 1'b0;
  localparam logic RUN_RST = 1'b0;
  localparam logic [7:0] WDT_CLR_VAL = 8'h00;

  // ----------------------------------------
  // Instruction patterns
  // ----------------------------------------
  localparam int DEST_BIT = 7;
  localparam logic [INSTR_W-1:0] MASK_FD = 14'h3f00;
  localparam logic [INSTR_W-1:0] PAT_MOVE_FILE = 14'h0800;
  localparam logic [INSTR_W-1:0] PAT_ROT_LEFT = 14'h0d00;
  localparam logic [INSTR_W-1:0] MASK_STORE = 14'h3f80;
  localparam logic [INSTR_W-1:0] PAT_STORE = 14'h0080;
  localparam logic [INSTR_W-1:0] MASK_LIT = 14'h3c00;
  localparam logic [INSTR_W-1:0] PAT_LOAD_LIT = 14'h3000;
  localparam logic [INSTR_W-1:0] PAT_RET_LIT = 14'h3400;
  localparam logic [INSTR_W-1:0] MASK_SUBL = 14'h3e00;
  localparam logic [INSTR_W-1:0] PAT_SUBL = 14'h3c00;
  localparam logic [INSTR_W-1:0] MASK_FULL = 14'h3fff;
  localparam logic [INSTR_W-1:0] PAT_RET_IRQ = 14'h0009;
  localparam logic [INSTR_W-1:0] PAT_RET_SUB = 14'h0008;
  localparam logic [INSTR_W-1:0] PAT_HALT = 14'h0063;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_RUN = 2'b01,
    ST_FLUSH = 2'b10,
    ST_SLEEP = 2'b11
  } cise_state_type;

  typedef enum logic [1:0] {
    ALU_PASS = 2'b00,
    ALU_RLC = 2'b01,
    ALU_SUBL = 2'b10
  } cise_alu_op_type;

endpackage

// >>> design/cise_alu_if.sv
// Carrier between the executor core and its arithmetic unit.
// Assumes a purely combinational unit on the far side.
`timescale 1ns/1ns
interface cise_alu_if;
  cise_pkg::cise_alu_op_type op;
  logic [7:0] opnd;
  logic [7:0] acc;
  logic cin;
  logic [7:0] res;
  logic cout;
  logic dcout;
  logic zout;

  modport core (output op, output opnd, output acc, output cin,
                input res, input cout, input dcout, input zout);
  modport unit (input op, input opnd, input acc, input cin,
                output res, output cout, output dcout, output zout);
endinterface

// >>> design/cise_alu.sv
// Arithmetic unit: pass, rotate left through carry, literal minus accumulator.
// Assumes the core picks which result flags it keeps.
`timescale 1ns/1ns
module cise_alu (
  // Operands and results
  cise_alu_if.unit alu
);

  logic [8:0] diff;
  logic [4:0] ndiff;

  always_comb begin
    diff = {1'b0, alu.opnd} - {1'b0, alu.acc};
    ndiff = {1'b0, alu.opnd[3:0]} - {1'b0, alu.acc[3:0]};
    alu.res = alu.opnd;
    alu.cout = alu.cin;
    alu.dcout = 1'b0;
    unique case (alu.op)
      cise_pkg::ALU_RLC: begin
        alu.res = {alu.opnd[6:0], alu.cin};
        alu.cout = alu.opnd[7];
      end
      cise_pkg::ALU_SUBL: begin
        // Carry and digit carry read as "no borrow"
        alu.res = diff[7:0];
        alu.cout = ~diff[8];
        alu.dcout = ~ndiff[4];
      end
      default: begin
        alu.res = alu.opnd;
      end
    endcase
    alu.zout = (alu.res == 8'h00);
  end

endmodule

// >>> design/cise_core.sv
// Executor of a subset of an 8-bit core's instruction set, with APB access.
// Assumes program memory, file register read and return stack answer
// combinationally within the cycle; watchdog lives outside.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns

// Behaviour
// - File move copies register at 7-bit address to selected destination.
// - Destination bit clear targets accumulator, set targets the file register.
// - File move updates zero flag from moved value.
// - Load literal puts 8-bit value in accumulator, flags untouched.
// - Store writes accumulator to addressed file register, flags untouched.
// - Interrupt return loads PC from stack top, sets global enable.
// - Literal return loads accumulator, pops PC, keeps flags, two cycles.
// - Subroutine return pops stack into PC, keeps flags, two cycles.
// - Rotate left through carry, only carry affected, destination selectable.
// - Halt clears watchdog and prescaler, sets timeout, clears powerdown.
// - In the same cycle as those updates halt enters sleep with oscillator stopped.
// - Literal minus accumulator into accumulator, updates carry, digit carry, zero.
module cise_core (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [cise_pkg::APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Program memory
  output logic [cise_pkg::PC_W-1:0] pmem_addr_o,
  input wire logic [cise_pkg::INSTR_W-1:0] pmem_data_i,
  // File registers
  output logic [cise_pkg::FADDR_W-1:0] file_raddr_o,
  input wire logic [7:0] file_rdata_i,
  output logic file_we_o,
  output logic [cise_pkg::FADDR_W-1:0] file_waddr_o,
  output logic [7:0] file_wdata_o,
  // Return stack
  input wire logic [cise_pkg::PC_W-1:0] stack_top_i,
  output logic stack_pop_o,
  // Watchdog, power and interrupt enable
  output logic wdt_clear_o,
  output logic [7:0] wdt_value_o,
  output logic osc_stop_o,
  input wire logic wake_i,
  output logic global_irq_enable_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    cise_pkg::cise_state_type st;
    logic run;
    logic [cise_pkg::PC_W-1:0] pc;
    logic [7:0] acc;
    logic c;
    logic dc;
    logic z;
    logic to_stat;
    logic pd_stat;
    logic global_irq_enable;
    logic fw_en;
    logic [cise_pkg::FADDR_W-1:0] fw_addr;
    logic [7:0] fw_data;
    logic wdt_clr;
    logic [31:0] rdata;
    logic err;
  } cise_core_type;

  cise_core_type s_q;
  cise_core_type s_d;

  cise_alu_if alu ();

  cise_alu u_alu (
    .alu(alu)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic is_op(
    input logic [cise_pkg::INSTR_W-1:0] ins,
    input logic [cise_pkg::INSTR_W-1:0] mask,
    input logic [cise_pkg::INSTR_W-1:0] pat
  );
    is_op = ((ins & mask) == pat);
  endfunction

  function automatic logic is_mapped(input logic [cise_pkg::APB_AW-1:0] a);
    is_mapped = (a == cise_pkg::CTRL_OFS) || (a == cise_pkg::STAT_OFS) ||
                (a == cise_pkg::ACC_OFS) || (a == cise_pkg::PC_OFS);
  endfunction

  logic [cise_pkg::INSTR_W-1:0] ins;
  logic [cise_pkg::FADDR_W-1:0] faddr;
  logic [7:0] lit;
  logic dest_file;
  logic [7:0] fval;
  logic setup;
  logic wr_acc;
  logic [31:0] stat_word;

  assign ins = pmem_data_i;
  assign faddr = ins[cise_pkg::FADDR_W-1:0];
  assign lit = ins[7:0];
  assign dest_file = ins[cise_pkg::DEST_BIT];
  assign setup = psel_i & ~penable_i;
  assign wr_acc = psel_i & penable_i & pwrite_i;

  // Store is registered, so a read of the same address one cycle later
  // would see stale memory; forward the pending write instead.
  assign fval = (s_q.fw_en && (s_q.fw_addr == faddr)) ? s_q.fw_data : file_rdata_i;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[cise_pkg::STAT_C_BIT] = s_q.c;
    stat_word[cise_pkg::STAT_DC_BIT] = s_q.dc;
    stat_word[cise_pkg::STAT_Z_BIT] = s_q.z;
    stat_word[cise_pkg::STAT_PD_BIT] = s_q.pd_stat;
    stat_word[cise_pkg::STAT_TO_BIT] = s_q.to_stat;
    stat_word[cise_pkg::STAT_GIE_BIT] = s_q.global_irq_enable;
    stat_word[cise_pkg::STAT_SLEEP_BIT] = (s_q.st == cise_pkg::ST_SLEEP);
    stat_word[cise_pkg::STAT_RUN_BIT] = (s_q.st != cise_pkg::ST_STOP);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.fw_en = 1'b0;
    s_d.wdt_clr = 1'b0;
    stack_pop_o = 1'b0;
    alu.op = cise_pkg::ALU_PASS;
    alu.opnd = fval;
    alu.acc = s_q.acc;
    alu.cin = s_q.c;

    // APB register side; ACC and PC only take writes while stopped
    if (setup) begin
      s_d.err = ~is_mapped(paddr_i);
      unique case (paddr_i)
        cise_pkg::CTRL_OFS: s_d.rdata = {31'h0000_0000, s_q.run};
        cise_pkg::STAT_OFS: s_d.rdata = stat_word;
        cise_pkg::ACC_OFS: s_d.rdata = {24'h00_0000, s_q.acc};
        cise_pkg::PC_OFS: s_d.rdata = {19'h0_0000, s_q.pc};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_acc) begin
      if (paddr_i == cise_pkg::CTRL_OFS) begin
        s_d.run = pwdata_i[cise_pkg::CTRL_RUN_BIT];
      end
      if (paddr_i == cise_pkg::STAT_OFS) begin
        s_d.global_irq_enable = pwdata_i[cise_pkg::STAT_GIE_BIT];
      end
      if (paddr_i == cise_pkg::ACC_OFS && s_q.st == cise_pkg::ST_STOP) begin
        s_d.acc = pwdata_i[7:0];
      end
      if (paddr_i == cise_pkg::PC_OFS && s_q.st == cise_pkg::ST_STOP) begin
        s_d.pc = pwdata_i[cise_pkg::PC_W-1:0];
      end
    end

    unique case (s_q.st)
      cise_pkg::ST_STOP: begin
        if (s_q.run) begin
          s_d.st = cise_pkg::ST_RUN;
        end
      end
      cise_pkg::ST_RUN: begin
        if (!s_q.run) begin
          s_d.st = cise_pkg::ST_STOP;
        end else begin
          s_d.pc = s_q.pc + 13'h0001;
          if (is_op(ins, cise_pkg::MASK_FD, cise_pkg::PAT_MOVE_FILE)) begin
            alu.op = cise_pkg::ALU_PASS;
            s_d.z = alu.zout;
            if (dest_file) begin
              s_d.fw_en = 1'b1;
              s_d.fw_addr = faddr;
              s_d.fw_data = alu.res;
            end else begin
              s_d.acc = alu.res;
            end
          end else if (is_op(ins, cise_pkg::MASK_FD, cise_pkg::PAT_ROT_LEFT)) begin
            alu.op = cise_pkg::ALU_RLC;
            s_d.c = alu.cout;
            if (dest_file) begin
              s_d.fw_en = 1'b1;
              s_d.fw_addr = faddr;
              s_d.fw_data = alu.res;
            end else begin
              s_d.acc = alu.res;
            end
          end else if (is_op(ins, cise_pkg::MASK_STORE, cise_pkg::PAT_STORE)) begin
            s_d.fw_en = 1'b1;
            s_d.fw_addr = faddr;
            s_d.fw_data = s_q.acc;
          end else if (is_op(ins, cise_pkg::MASK_LIT, cise_pkg::PAT_LOAD_LIT)) begin
            s_d.acc = lit;
          end else if (is_op(ins, cise_pkg::MASK_LIT, cise_pkg::PAT_RET_LIT)) begin
            s_d.acc = lit;
            s_d.pc = stack_top_i;
            stack_pop_o = 1'b1;
            s_d.st = cise_pkg::ST_FLUSH;
          end else if (is_op(ins, cise_pkg::MASK_SUBL, cise_pkg::PAT_SUBL)) begin
            alu.op = cise_pkg::ALU_SUBL;
            alu.opnd = lit;
            s_d.acc = alu.res;
            s_d.c = alu.cout;
            s_d.dc = alu.dcout;
            s_d.z = alu.zout;
          end else if (is_op(ins, cise_pkg::MASK_FULL, cise_pkg::PAT_RET_IRQ)) begin
            s_d.pc = stack_top_i;
            stack_pop_o = 1'b1;
            s_d.global_irq_enable = 1'b1;
            s_d.st = cise_pkg::ST_FLUSH;
          end else if (is_op(ins, cise_pkg::MASK_FULL, cise_pkg::PAT_RET_SUB)) begin
            s_d.pc = stack_top_i;
            stack_pop_o = 1'b1;
            s_d.st = cise_pkg::ST_FLUSH;
          end else if (is_op(ins, cise_pkg::MASK_FULL, cise_pkg::PAT_HALT)) begin
            s_d.wdt_clr = 1'b1;
            s_d.to_stat = 1'b1;
            s_d.pd_stat = 1'b0;
            s_d.st = cise_pkg::ST_SLEEP;
          end
          // Anything else behaves as an idle instruction
        end
      end
      cise_pkg::ST_FLUSH: begin
        // Second cycle of a return: the word fetched is discarded
        s_d.st = s_q.run ? cise_pkg::ST_RUN : cise_pkg::ST_STOP;
      end
      cise_pkg::ST_SLEEP: begin
        // Clearing run does not wake the core; only wake_i does
        if (wake_i) begin
          s_d.st = s_q.run ? cise_pkg::ST_RUN : cise_pkg::ST_STOP;
        end
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q.st <= cise_pkg::ST_STOP;
      s_q.run <= cise_pkg::RUN_RST;
      s_q.pc <= cise_pkg::PC_RST;
      s_q.acc <= cise_pkg::ACC_RST;
      s_q.c <= 1'b0;
      s_q.dc <= 1'b0;
      s_q.z <= 1'b0;
      s_q.to_stat <= cise_pkg::TO_RST;
      s_q.pd_stat <= cise_pkg::PD_RST;
      s_q.global_irq_enable <= cise_pkg::GIE_RST;
      s_q.fw_en <= 1'b0;
      s_q.fw_addr <= 7'h00;
      s_q.fw_data <= 8'h00;
      s_q.wdt_clr <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
      s_q.err <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata_o = s_q.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & s_q.err;
  assign pmem_addr_o = s_q.pc;
  assign file_raddr_o = faddr;
  assign file_we_o = s_q.fw_en;
  assign file_waddr_o = s_q.fw_addr;
  assign file_wdata_o = s_q.fw_data;
  assign wdt_clear_o = s_q.wdt_clr;
  assign wdt_value_o = cise_pkg::WDT_CLR_VAL;
  assign osc_stop_o = (s_q.st == cise_pkg::ST_SLEEP);
  assign global_irq_enable_o = s_q.global_irq_enable;

endmodule

// >>> test/cise_core_assertions.sv
// Checker of the executor core, watching only its top-level ports.
// Assumes one instruction per rising edge of sys_clk_i.
`timescale 1ns/1ns
module cise_core_checker (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Observed ports
  input wire logic [cise_pkg::PC_W-1:0] pmem_addr_o,
  input wire logic [cise_pkg::INSTR_W-1:0] pmem_data_i,
  input wire logic [cise_pkg::FADDR_W-1:0] file_raddr_o,
  input wire logic [7:0] file_rdata_i,
  input wire logic file_we_o,
  input wire logic [cise_pkg::FADDR_W-1:0] file_waddr_o,
  input wire logic [7:0] file_wdata_o,
  input wire logic [cise_pkg::PC_W-1:0] stack_top_i,
  input wire logic stack_pop_o,
  input wire logic wdt_clear_o,
  input wire logic [7:0] wdt_value_o,
  input wire logic osc_stop_o,
  input wire logic wake_i,
  input wire logic global_irq_enable_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ----
  // Properties
  // ----
  property p_file_addr;
    file_we_o |-> file_waddr_o == $past(file_raddr_o);
  endproperty
  a_file_addr: assert property (p_file_addr) else $error("write address");
  property p_dest_sel;
    file_we_o |-> $past(pmem_data_i[7]) || ($past(pmem_data_i & 14'h3f80) == 14'h0080);
  endproperty
  a_dest_sel: assert property (p_dest_sel) else $error("write with d clear");
  // Skipped after a write: the read is then forwarded inside the core
  property p_move_data;
    file_we_o && !$past(file_we_o) && ($past(pmem_data_i & 14'h3f00) == 14'h0800)
      |-> file_wdata_o == $past(file_rdata_i);
  endproperty
  a_move_data: assert property (p_move_data) else $error("moved value");
  property p_pop_pc;
    stack_pop_o |=> pmem_addr_o == $past(stack_top_i);
  endproperty
  a_pop_pc: assert property (p_pop_pc) else $error("return address");
  property p_two_cycle;
    // The flush cycle must hold the fetch address on the return target
    stack_pop_o |=> !stack_pop_o ##1 ($stable(pmem_addr_o) && !file_we_o);
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("flush cycle");
  property p_gie;
    stack_pop_o && pmem_data_i == 14'h0009 |=> global_irq_enable_o;
  endproperty
  a_gie: assert property (p_gie) else $error("irq enable not set");
  property p_wdt_pulse;
    wdt_clear_o == $rose(osc_stop_o);
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog clear");
  property p_wdt_value;
    wdt_value_o == 8'h00;
  endproperty
  a_wdt_value: assert property (p_wdt_value) else $error("watchdog value");
  property p_sleep_hold;
    osc_stop_o && !wake_i |=> osc_stop_o && $stable(pmem_addr_o) && !file_we_o;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("left sleep");
  c_irq_ret: cover property (stack_pop_o && pmem_data_i == 14'h0009);
  c_sleep: cover property (wdt_clear_o);
  c_zero: cover property (file_we_o && file_wdata_o == 8'h00);
endmodule

bind cise_core cise_core_checker chk_u (.*);

// >>> test/cise_far_model.sv
// Far-side model: program memory, file registers and return stack.
// Assumes the core reads all three within the same cycle.
`timescale 1ns/1ns
module cise_far_model (
  // Clock
  input wire logic sys_clk_i,
  // Core side
  input wire logic [12:0] pmem_addr_i,
  output logic [13:0] pmem_data_o,
  input wire logic [6:0] file_raddr_i,
  output logic [7:0] file_rdata_o,
  input wire logic file_we_i,
  input wire logic [6:0] file_waddr_i,
  input wire logic [7:0] file_wdata_i,
  output logic [12:0] stack_top_o,
  input wire logic stack_pop_i
);
  logic [13:0] pmem [0:31];
  logic [7:0] fmem [0:127];
  logic [12:0] stk [0:7];
  int sp = 0;
  // Beyond the image the fetch bus shows all ones, not a stale word
  assign pmem_data_o = (pmem_addr_i < 13'h0020) ? pmem[pmem_addr_i[4:0]] : 14'h3fff;
  assign file_rdata_o = fmem[file_raddr_i];
  assign stack_top_o = stk[sp[2:0]];
  always @(posedge sys_clk_i) begin
    if (file_we_i) begin
      fmem[file_waddr_i] <= file_wdata_i;
    end
    if (stack_pop_i) begin
      sp <= sp + 1;
    end
  end
endmodule

// >>> test/tb_top.sv
// Bench of the executor core: random programs checked against a model.
// Assumes the far-side model and the bound checker.
`timescale 1ns/1ns
module tb_top;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic wake_i = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, file_we_o, stack_pop_o, wdt_clear_o, osc_stop_o;
  logic global_irq_enable_o;
  logic [12:0] pmem_addr_o, stack_top_i;
  logic [13:0] pmem_data_i;
  logic [6:0] file_raddr_o, file_waddr_o;
  logic [7:0] file_rdata_i, file_wdata_o, wdt_value_o;
  int err_count = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h00016170;
  logic [31:0] rd;
  logic er;
  logic [13:0] pm [0:31];
  logic [12:0] tq [$];
  logic [7:0] m_f [0:127];
  logic [7:0] m_acc;
  logic m_c = 1'b0, m_dc = 1'b0, m_z = 1'b0, m_gie = 1'b0;
  logic [12:0] m_pc;

  cise_core dut_u (.*);
  cise_far_model far_u (.sys_clk_i(sys_clk_i), .pmem_addr_i(pmem_addr_o),
    .pmem_data_o(pmem_data_i), .file_raddr_i(file_raddr_o), .file_rdata_o(file_rdata_i),
    .file_we_i(file_we_o), .file_waddr_i(file_waddr_o), .file_wdata_i(file_wdata_o),
    .stack_top_o(stack_top_i), .stack_pop_i(stack_pop_o));

  always #5 sys_clk_i = ~sys_clk_i;

  // ----
  // Tasks
  // ----
  function automatic logic [31:0] lfsr_next();
    for (int i = 0; i < 32; i++) seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    return seed;
  endfunction
  task automatic give_verdict();
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic give_up();
    err_count++;
    $display("Error at %0t: wait ran out", $time);
    give_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Answer taken at the rising edge that ends the access phase, before that edge's updates
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    logic rdy;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
      rdy = pready_o;
      rd = prdata_o;
      er = pslverr_o;
    end while (rdy !== 1'b1 && n < 50);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (rdy !== 1'b1) give_up();
    @(posedge sys_clk_i);
  endtask
  task automatic wait_stop(input logic lvl);
    for (int n = 0; n < 300 && osc_stop_o !== lvl; n++) @(negedge sys_clk_i);
    if (osc_stop_o !== lvl) give_up();
    @(posedge sys_clk_i);
  endtask
  // Each return jumps over one word to an idle word, so a missed jump shows
  task automatic build_round();
    int a;
    logic [31:0] r;
    a = 0;
    tq.delete();
    while (a < 24) begin
      r = lfsr_next();
      case (r[19:16] % 9)
        0: pm[a] = cise_pkg::PAT_MOVE_FILE | 14'(r[15:8]);
        1: pm[a] = cise_pkg::PAT_ROT_LEFT | 14'(r[15:8]);
        2: pm[a] = cise_pkg::PAT_STORE | 14'(r[14:8]);
        3: pm[a] = cise_pkg::PAT_LOAD_LIT | 14'(r[9:0]);
        4: pm[a] = cise_pkg::PAT_SUBL | 14'(r[7:0]);
        5: pm[a] = 14'h0000;
        6: pm[a] = cise_pkg::PAT_RET_LIT | 14'(r[7:0]);
        7: pm[a] = cise_pkg::PAT_RET_SUB;
        default: pm[a] = cise_pkg::PAT_RET_IRQ;
      endcase
      if (r[19:16] % 9 > 5) begin
        pm[a + 1] = cise_pkg::PAT_STORE | 14'(r[14:8]);
        pm[a + 2] = 14'h0000;
        tq.push_back(13'(a + 2));
        a += 3;
      end else a++;
    end
    pm[a] = cise_pkg::PAT_HALT;
    for (int i = a + 1; i < 32; i++) pm[i] = 14'h0000;
    for (int i = 0; i < 32; i++) far_u.pmem[i] = pm[i];
    for (int i = 0; i < 8; i++) far_u.stk[i] = (i < tq.size()) ? tq[i] : 13'h1fff;
    far_u.sp = 0;
    for (int i = 0; i < 128; i++) begin
      m_f[i] = (i % 4 == 0) ? 8'h00 : 8'(lfsr_next() >> 24);
      far_u.fmem[i] = m_f[i];
    end
    m_acc = 8'(lfsr_next() >> 24);
  endtask
  task automatic run_model();
    logic [13:0] ins;
    logic [7:0] v;
    m_pc = 13'h0000;
    for (int n = 0; n < 40; n++) begin
      ins = pm[m_pc];
      m_pc++;
      if (ins == cise_pkg::PAT_HALT) break;
      if ((ins & cise_pkg::MASK_FD) inside {cise_pkg::PAT_MOVE_FILE, cise_pkg::PAT_ROT_LEFT}) begin
        v = m_f[ins[6:0]];
        if (ins[8]) {m_c, v} = {v, m_c};
        else m_z = (v == 8'h00);
        if (ins[7]) m_f[ins[6:0]] = v;
        else m_acc = v;
      end else if ((ins & cise_pkg::MASK_STORE) == cise_pkg::PAT_STORE) m_f[ins[6:0]] = m_acc;
      else if ((ins & cise_pkg::MASK_LIT) == cise_pkg::PAT_LOAD_LIT) m_acc = ins[7:0];
      else if ((ins & cise_pkg::MASK_SUBL) == cise_pkg::PAT_SUBL) begin
        m_c = ins[7:0] >= m_acc;
        m_dc = ins[3:0] >= m_acc[3:0];
        m_acc = ins[7:0] - m_acc;
        m_z = (m_acc == 8'h00);
      end else if ((ins & cise_pkg::MASK_LIT) == cise_pkg::PAT_RET_LIT || ins[13:1] == 13'h0004) begin
        if (ins[13]) m_acc = ins[7:0];
        if (ins == cise_pkg::PAT_RET_IRQ) m_gie = 1'b1;
        m_pc = tq.pop_front();
      end
    end
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    apb(1'b0, cise_pkg::STAT_OFS, 32'h0);
    chk(rd, 32'h18);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    for (int rn = 0; rn < 6; rn++) begin
      build_round();
      apb(1'b1, cise_pkg::ACC_OFS, {24'h0, m_acc});
      apb(1'b1, cise_pkg::PC_OFS, 32'h0);
      apb(1'b1, cise_pkg::STAT_OFS, 32'h0);
      m_gie = 1'b0;
      run_model();
      apb(1'b1, cise_pkg::CTRL_OFS, 32'h1);
      wait_stop(1'b1);
      apb(1'b1, cise_pkg::ACC_OFS, 32'h5a);
      apb(1'b1, cise_pkg::PC_OFS, 32'h1f);
      apb(1'b0, cise_pkg::ACC_OFS, 32'h0);
      chk(rd, {24'h0, m_acc});
      apb(1'b0, cise_pkg::STAT_OFS, 32'h0);
      chk(rd, {24'h0, 2'b11, m_gie, 2'b10, m_z, m_dc, m_c});
      apb(1'b0, cise_pkg::PC_OFS, 32'h0);
      chk(rd, {19'h0, m_pc});
      for (int i = 0; i < 128; i++) chk({24'h0, far_u.fmem[i]}, {24'h0, m_f[i]});
      apb(1'b1, cise_pkg::CTRL_OFS, 32'h0);
      wake_i <= 1'b1;
      wait_stop(1'b0);
      wake_i <= 1'b0;
      for (int n = 0; n < 8; n++) begin
        apb(1'b0, cise_pkg::STAT_OFS, 32'h0);
        if (rd[7] === 1'b0) break;
      end
      if (rd[7] !== 1'b0) give_up();
    end
    give_verdict();
  end
endmodule
